// file: rtl/dcm_regs.vh
// register map and field constants for the dc level measurement block
`ifndef DCM_REGS_VH
`define DCM_REGS_VH

// ****************************************
// register indices (byte address is four times the index)
// ****************************************
`define DCM_IDX_CTRL_A      7'h66
`define DCM_IDX_CTRL_B      7'h67
`define DCM_IDX_LEFT_HI     7'h68
`define DCM_IDX_LEFT_MID    7'h69
`define DCM_IDX_LEFT_LO     7'h6a
`define DCM_IDX_RIGHT_HI    7'h6b
`define DCM_IDX_RIGHT_MID   7'h6c
`define DCM_IDX_RIGHT_LO    7'h6d
`define DCM_IDX_SAMPLE      7'h70

// ****************************************
// fields of control register a
// ****************************************
`define DCM_A_LEFT_EN       7
`define DCM_A_RIGHT_EN      6
`define DCM_A_IIR_SEL       5
`define DCM_A_EXP_HI        4

// ****************************************
// fields of control register b
// ****************************************
`define DCM_B_HOLD          6
`define DCM_B_LATCH_SEL     5
`define DCM_B_AVG_HI        4

// ****************************************
// reset values and limits
// ****************************************
`define DCM_CTRL_RESET      8'h00
`define DCM_RESULT_RESET    24'h000000
`define DCM_B_WMASK         8'h7f
`define DCM_CODE_MAX        5'h14
`define DCM_ACC_W           48
`define DCM_RES_W           24

`endif

// file: rtl/dcm_wb_slave.v
// classic wishbone slave front end: decode, one-cycle ack, byte mux
`timescale 1ns/1ps
`default_nettype none
`include "dcm_regs.vh"

module dcm_wb_slave (
    // clock and reset
    input  wire        clock,
    input  wire        reset,
    // wishbone
    input  wire [31:0] wbAdr,
    input  wire [31:0] wbDatW,
    input  wire [3:0]  wbSel,
    input  wire        wbWe,
    input  wire        wbCyc,
    input  wire        wbStb,
    output reg  [31:0] wbDatR,
    output reg         wbAck,
    // register side
    output wire [6:0]  regIdx,
    output wire        regWr,
    output wire [7:0]  regWData,
    input  wire [7:0]  regRData
);

    // strobe only on a fresh request, never in the ack cycle
    wire req = wbCyc & wbStb & ~wbAck;

    assign regIdx   = wbAdr[8:2];
    // write lands at the edge where the master sees ack high
    assign regWr    = wbCyc & wbStb & wbAck & wbWe & wbSel[0] &
                      (wbAdr[31:9] == 23'h000000);
    assign regWData = wbDatW[7:0];

    // ****************************************
    // ack and read data
    // ****************************************
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            wbAck  <= 1'b0;
            wbDatR <= 32'h00000000;
        end else begin
            wbAck  <= req;
            if (req && !wbWe) begin
                if (wbAdr[31:9] == 23'h000000)
                    wbDatR <= {24'h000000, regRData};
                else
                    wbDatR <= 32'h00000000;
            end
        end
    end

endmodule
`default_nettype wire

// file: rtl/dcm_channel.v
// one channel of dc level measurement: moving average or iir
`timescale 1ns/1ps
`default_nettype none
`include "dcm_regs.vh"

module dcm_channel (
    // clock and reset
    input  wire        clock,
    input  wire        reset,
    // controls
    input  wire        enable,
    input  wire        iirMode,
    input  wire [4:0]  expCode,
    input  wire [4:0]  avgCode,
    input  wire        latchSel,
    input  wire        hold,
    // samples
    input  wire        sampleStb,
    input  wire [23:0] sample,
    // result
    output reg  [23:0] result
);

    reg  [47:0] acc_q;      // moving-average sum or iir state
    reg  [20:0] cnt_q;      // samples in window or period
    wire [47:0] sx   = {{24{sample[23]}}, sample};
    wire [47:0] iirY = $signed(acc_q) >>> expCode;
    wire [20:0] winLen  = 21'h000001 << expCode;
    wire [20:0] avgLen  = 21'h000001 << avgCode;
    wire [47:0] avgOut  = $signed(acc_q + sx) >>> expCode;
    wire        winEnd  = (cnt_q == winLen - 21'h000001);
    wire        perEnd  = (avgCode != 5'h00) &&
                          (cnt_q == avgLen - 21'h000001);

    // ****************************************
    // filter state, runs only while enabled
    // ****************************************
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            acc_q  <= 48'h000000000000;
            cnt_q  <= 21'h000000;
            result <= `DCM_RESULT_RESET;
        end else if (!enable) begin
            acc_q <= 48'h000000000000;
            cnt_q <= 21'h000000;
        end else if (sampleStb) begin
            if (!iirMode) begin
                // box sum over 2^exp samples, then restart
                if (winEnd) begin
                    acc_q <= 48'h000000000000;
                    cnt_q <= 21'h000000;
                    if (!hold)
                        result <= avgOut[23:0];
                end else begin
                    acc_q <= acc_q + sx;
                    cnt_q <= cnt_q + 21'h000001;
                end
            end else begin
                // y += (x - y) / 2^exp, state scaled by 2^exp
                if (perEnd) begin
                    acc_q <= 48'h000000000000;
                    cnt_q <= 21'h000000;
                end else begin
                    acc_q <= acc_q + sx - iirY;
                    if (avgCode != 5'h00)
                        cnt_q <= cnt_q + 21'h000001;
                end
                // select 1 takes the output only just before a clear
                if (!hold && (!latchSel || perEnd))
                    result <= iirY[23:0];
            end
        end
    end

endmodule
`default_nettype wire

// file: rtl/dcm_top.v
// dc level measurement block: registers and two channel filters
// ****************************************
// Notes on behaviour
// - left measurement runs only when enabled
// - right measurement runs only when enabled
// - type 0: moving average over 2^exp
// - type 1: first-order iir from exponent
// - exponent field codes 1..20 used directly
// - hold bit freezes both results
// - select 0: report instantaneous iir output
// - select 1: latch output before clearing
// - averaging period is 2^n modulator clocks
// - averaging code zero never clears filter
// - results 24-bit, three bytes, msb first
// ****************************************
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "dcm_regs.vh"

module dcm_top (
    // clock and reset
    input  wire        clock,
    input  wire        reset,
    // wishbone
    input  wire [31:0] wbAdr,
    input  wire [31:0] wbDatW,
    input  wire [3:0]  wbSel,
    input  wire        wbWe,
    input  wire        wbCyc,
    input  wire        wbStb,
    output wire [31:0] wbDatR,
    output wire        wbAck,
    // adc samples, one strobe per modulator clock
    input  wire        modStb,
    input  wire [23:0] leftSample,
    input  wire [23:0] rightSample
);

    wire [6:0]  regIdx;
    wire        regWr;
    wire [7:0]  regWData;
    reg  [7:0]  regRData;
    reg  [7:0]  ctrlA_q;
    reg  [7:0]  ctrlB_q;
    wire [23:0] leftRes;
    wire [23:0] rightRes;

    // ****************************************
    // bus front end
    // ****************************************
    dcm_wb_slave uBus (
        .clock    (clock),
        .reset    (reset),
        .wbAdr    (wbAdr),
        .wbDatW   (wbDatW),
        .wbSel    (wbSel),
        .wbWe     (wbWe),
        .wbCyc    (wbCyc),
        .wbStb    (wbStb),
        .wbDatR   (wbDatR),
        .wbAck    (wbAck),
        .regIdx   (regIdx),
        .regWr    (regWr),
        .regWData (regWData),
        .regRData (regRData)
    );

    // ****************************************
    // control registers
    // ****************************************
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            ctrlA_q <= `DCM_CTRL_RESET;
            ctrlB_q <= `DCM_CTRL_RESET;
        end else if (regWr) begin
            if (regIdx == `DCM_IDX_CTRL_A)
                ctrlA_q <= regWData;
            if (regIdx == `DCM_IDX_CTRL_B)
                ctrlB_q <= regWData & `DCM_B_WMASK;  // top bit read-only
        end
    end

    // ****************************************
    // read mux
    // ****************************************
    always @* begin
        case (regIdx)
            `DCM_IDX_CTRL_A:    regRData = ctrlA_q;
            `DCM_IDX_CTRL_B:    regRData = ctrlB_q;
            `DCM_IDX_LEFT_HI:   regRData = leftRes[23:16];
            `DCM_IDX_LEFT_MID:  regRData = leftRes[15:8];
            `DCM_IDX_LEFT_LO:   regRData = leftRes[7:0];
            `DCM_IDX_RIGHT_HI:  regRData = rightRes[23:16];
            `DCM_IDX_RIGHT_MID: regRData = rightRes[15:8];
            `DCM_IDX_RIGHT_LO:  regRData = rightRes[7:0];
            default:            regRData = 8'h00;
        endcase
    end

    // ****************************************
    // channel filters, index 0 left, 1 right
    // ****************************************
    wire [1:0]  chanEn  = {ctrlA_q[`DCM_A_RIGHT_EN],
                           ctrlA_q[`DCM_A_LEFT_EN]};
    wire [47:0] chanSmp = {rightSample, leftSample};
    wire [47:0] chanRes;

    // split the packed results back per channel
    assign leftRes  = chanRes[23:0];
    assign rightRes = chanRes[47:24];

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : gChan
            dcm_channel uChan (
                .clock     (clock),
                .reset     (reset),
                .enable    (chanEn[ch]),
                .iirMode   (ctrlA_q[`DCM_A_IIR_SEL]),
                .expCode   (ctrlA_q[`DCM_A_EXP_HI:0]),
                .avgCode   (ctrlB_q[`DCM_B_AVG_HI:0]),
                .latchSel  (ctrlB_q[`DCM_B_LATCH_SEL]),
                .hold      (ctrlB_q[`DCM_B_HOLD]),
                .sampleStb (modStb),
                .sample    (chanSmp[ch*24 +: 24]),
                .result    (chanRes[ch*24 +: 24])
            );
        end
    endgenerate

endmodule
`default_nettype wire

// file: test/dcm_top_asserts.sv
// port checker for the dc level measurement block
`timescale 1ns/1ps
`default_nettype none
module dcm_top_asserts (
    // clock and reset
    input wire logic        clock,
    input wire logic        reset,
    // wishbone
    input wire logic [31:0] wbAdr,
    input wire logic [31:0] wbDatW,
    input wire logic [3:0]  wbSel,
    input wire logic        wbWe,
    input wire logic        wbCyc,
    input wire logic        wbStb,
    input wire logic [31:0] wbDatR,
    input wire logic        wbAck
);
    wire logic [6:0] idx = wbAdr[8:2];
    wire logic       rd  = wbCyc && wbStb && wbAck && !wbWe;
    wire logic       wr  = wbCyc && wbStb && wbAck && wbWe && wbSel[0];
    logic [7:0]      ctrlA_q;
    logic [7:0]      ctrlB_q;
    logic            lOn_q;
    logic            rOn_q;
    wire logic       lOn = lOn_q || ctrlA_q[7];
    wire logic       rOn = rOn_q || ctrlA_q[6];
    // mirror control writes, remember any enable since reset
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            ctrlA_q <= 8'h00;
            ctrlB_q <= 8'h00;
            lOn_q   <= 1'b0;
            rOn_q   <= 1'b0;
        end else begin
            lOn_q <= lOn;
            rOn_q <= rOn;
            if (wr && idx == 7'h66) ctrlA_q <= wbDatW[7:0];
            if (wr && idx == 7'h67) ctrlB_q <= wbDatW[7:0];
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);
    property p_ackNext; wbCyc && wbStb && !wbAck |=> wbAck; endproperty
    a_ackNext: assert property (p_ackNext) else $error("ack late");
    property p_ackOne; wbAck |=> !wbAck; endproperty
    a_ackOne: assert property (p_ackOne) else $error("ack long");
    property p_upper; rd |-> wbDatR[31:8] == 24'h000000; endproperty
    a_upper: assert property (p_upper) else $error("upper bits");
    property p_ctrlA; rd && idx == 7'h66 |-> wbDatR[7:0] == ctrlA_q; endproperty
    a_ctrlA: assert property (p_ctrlA) else $error("ctrl a");
    property p_ctrlB;
        rd && idx == 7'h67 |-> wbDatR[7:0] == {1'b0, ctrlB_q[6:0]};
    endproperty
    a_ctrlB: assert property (p_ctrlB) else $error("ctrl b");
    property p_lOff;
        rd && idx >= 7'h68 && idx <= 7'h6a && !lOn |-> wbDatR[7:0] == 8'h00;
    endproperty
    a_lOff: assert property (p_lOff) else $error("left moved");
    property p_rOff;
        rd && idx >= 7'h6b && idx <= 7'h6d && !rOn |-> wbDatR[7:0] == 8'h00;
    endproperty
    a_rOff: assert property (p_rOff) else $error("right moved");
    property p_spare; rd && idx[6:1] == 6'h37 |-> wbDatR == 32'h0; endproperty
    a_spare: assert property (p_spare) else $error("spare read");
endmodule
bind dcm_top dcm_top_asserts u_dcm_top_asserts (.clock(clock), .reset(reset),
    .wbAdr(wbAdr), .wbDatW(wbDatW), .wbSel(wbSel), .wbWe(wbWe),
    .wbCyc(wbCyc), .wbStb(wbStb), .wbDatR(wbDatR), .wbAck(wbAck));
`default_nettype wire

// file: test/test_adc_dc_level_measurement.sv
// self-checking bench for the dc level measurement block
`timescale 1ns/1ps
`default_nettype none
module test_adc_dc_level_measurement;
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic [31:0] wbAdr = 32'h0;
    logic [31:0] wbDatW = 32'h0;
    logic [3:0]  wbSel = 4'h1;
    logic        wbWe = 1'b0;
    logic        wbCyc = 1'b0;
    logic        wbStb = 1'b0;
    logic        modStb = 1'b0;
    logic [23:0] lSmp = 24'h0;
    logic [23:0] rSmp = 24'h0;
    logic [7:0]  q;
    wire logic [31:0] wbDatR;
    wire logic        wbAck;
    int          fail_count = 0;
    int          tests_run = 0;
    int          cycles = 0;
    dcm_top u_dcm_top (.clock(clock), .reset(reset), .wbAdr(wbAdr),
        .wbDatW(wbDatW), .wbSel(wbSel), .wbWe(wbWe), .wbCyc(wbCyc),
        .wbStb(wbStb), .wbDatR(wbDatR), .wbAck(wbAck), .modStb(modStb),
        .leftSample(lSmp), .rightSample(rSmp));
    // 50 mhz clock
    always #10 clock = ~clock;
    // one classic cycle, held until ack
    task automatic xfer(input logic [6:0] i, input logic we,
                        input logic [7:0] d, output logic [7:0] rq);
        wbAdr <= {23'h0, i, 2'b00};
        wbWe <= we;
        wbDatW <= {24'h0, d};
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        @(posedge clock);
        while (wbAck !== 1'b1) @(posedge clock);
        rq = wbDatR[7:0];
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        @(posedge clock);
    endtask
    task automatic check(input string s, input logic [23:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", s, exp, got);
        end
    endtask
    task automatic rd(input string s, input logic [6:0] i, input logic [7:0] e);
        logic [7:0] rq;
        xfer(i, 1'b0, 8'h00, rq);
        check(s, {16'h0, rq}, {16'h0, e});
    endtask
    // result is three bytes, msb at the lowest index
    task automatic res(input string s, input logic [6:0] i, input logic [23:0] e);
        rd(s, i, e[23:16]);
        rd(s, i + 7'h1, e[15:8]);
        rd(s, i + 7'h2, e[7:0]);
    endtask
    task automatic feed(input logic [23:0] l, r, input int n);
        lSmp <= l;
        rSmp <= r;
        repeat (n) begin
            modStb <= 1'b1;
            @(posedge clock);
            modStb <= 1'b0;
            @(posedge clock);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // hang guard
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            fail_count++;
            stop_test();
        end
    end
    initial begin
        repeat (20) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        for (int i = 0; i < 10; i++) rd("rst", 7'h66 + i[6:0], 8'h00);
        xfer(7'h67, 1'b1, 8'h74, q);
        rd("ctrlB", 7'h67, 8'h74);
        wbSel <= 4'h0;
        xfer(7'h66, 1'b1, 8'hc3, q);
        wbSel <= 4'h1;
        rd("sel", 7'h66, 8'h00);
        xfer(7'h68, 1'b1, 8'h5a, q);
        xfer(7'h6e, 1'b1, 8'h5a, q);
        for (int i = 2; i < 10; i++) rd("ro", 7'h66 + i[6:0], 8'h00);
        $display("registers done");
        xfer(7'h67, 1'b1, 8'h00, q);
        xfer(7'h66, 1'b1, 8'h82, q);
        feed(24'h000100, 24'h000200, 3);
        res("win3", 7'h68, 24'h000000);
        feed(24'h000100, 24'h000200, 5);
        res("avgL", 7'h68, 24'h000100);
        res("avgR", 7'h6b, 24'h000000);
        $display("average done");
        xfer(7'h66, 1'b1, 8'he1, q);
        feed(24'h000300, 24'hfffe00, 40);
        res("iirL", 7'h68, 24'h000300);
        res("iirR", 7'h6b, 24'hfffe00);
        xfer(7'h67, 1'b1, 8'h40, q);
        feed(24'h000500, 24'h000500, 40);
        res("hold", 7'h68, 24'h000300);
        xfer(7'h67, 1'b1, 8'h00, q);
        feed(24'h000500, 24'h000500, 40);
        res("free", 7'h68, 24'h000500);
        $display("iir done");
        xfer(7'h67, 1'b1, 8'h20, q);
        feed(24'h000700, 24'h000700, 40);
        res("latch0", 7'h68, 24'h000500);
        xfer(7'h67, 1'b1, 8'h25, q);
        feed(24'h000700, 24'h000700, 31);
        res("early", 7'h68, 24'h000500);
        feed(24'h000700, 24'h000700, 1);
        res("latch5", 7'h68, 24'h000700);
        xfer(7'h67, 1'b1, 8'h05, q);
        feed(24'h000700, 24'h000700, 1);
        res("clear", 7'h68, 24'h000000);
        $display("latch done");
        stop_test();
    end
endmodule
`default_nettype wire
